// ==== apm_pkg.sv ====
`default_nettype none
package apm_pkg;
  // ****************************************************************
  // timebase
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 32'h0000_000A; // 10 ns core clock
  // 400 Hz sample period, 2_500_000 ns
  localparam int ODR_MAX_PERIOD_NS = 32'h0026_25A0;
  localparam int ODR_MAX_CYC = ODR_MAX_PERIOD_NS / CLK_PERIOD_NS;
  // wake-up poll period, about six per second, 166_666_666 ns
  localparam int WAKE_PERIOD_NS = 32'h09EF_21AA;
  localparam int WAKE_CYC = WAKE_PERIOD_NS / CLK_PERIOD_NS;
  // odr code of the fastest rate (400 Hz); code 0 is 12.5 Hz
  localparam logic [2:0] ODR_TOP = 3'h5;

  // ****************************************************************
  // sample format
  // ****************************************************************
  localparam int AXES = 32'h0000_0003;
  localparam int RAW_W = 32'h0000_0010;
  localparam int SAMPLE_W = 32'h0000_000C;
  localparam logic signed [15:0] SMP_MAX = 16'sh07FF;
  localparam logic signed [15:0] SMP_MIN = 16'shF800;
  localparam logic [11:0] FULL_SCALE_CODE = 12'h0FFF;
  localparam int FIFO_DEPTH = 32'h0000_0010;
  localparam int FIFO_W = AXES * SAMPLE_W;

  // ****************************************************************
  // types
  // ****************************************************************
  // standby must stay first so an all-zero reset lands in it
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_MEAS,
    MODE_WAKE
  } apm_mode_t;

  typedef enum logic [1:0] {
    RANGE_2G,
    RANGE_4G,
    RANGE_8G
  } apm_range_t;

  typedef logic signed [RAW_W-1:0] apm_raw_axis_t;
  typedef apm_raw_axis_t [AXES-1:0] apm_raw_t;
  typedef logic [AXES-1:0][SAMPLE_W-1:0] apm_sample_t;

  typedef struct packed {
    apm_mode_t mode_req;
    apm_range_t range;
    logic [2:0] odr;
    logic [11:0] act_thresh;
    logic [7:0] act_time;
    logic auto_meas_en;
    logic irq_en;
    logic awake_en;
    logic fifo_en;
    logic ext_clk_en;
    logic sync_en;
  } apm_cfg_t;
endpackage
`default_nettype wire

// ==== apm_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module apm_fifo #(
  parameter int WIDTH = apm_pkg::FIFO_W,
  parameter int DEPTH = apm_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } apm_fifo_st_t;

  apm_fifo_st_t fifo_reg, fifo_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr, rd;

  // ****************************************************************
  // handshakes
  // ****************************************************************
  // the output register is an extra slot, so full means the array only
  assign in_ready = fifo_reg.cnt != (AW+1)'(DEPTH);
  assign wr = in_valid & in_ready;
  assign rd = (fifo_reg.cnt != '0) & (~fifo_reg.ov | out_ready);
  assign out_valid = fifo_reg.ov;
  assign out_data = fifo_reg.od;

  // ****************************************************************
  // pointers and output stage
  // ****************************************************************
  // read data always leaves through a register
  always_comb begin
    fifo_next = fifo_reg;
    if (out_ready) begin
      fifo_next.ov = 1'b0;
    end
    if (rd) begin
      fifo_next.ov = 1'b1;
      fifo_next.od = mem[fifo_reg.rp];
      fifo_next.rp = fifo_reg.rp + 1'b1;
    end
    if (wr) begin
      fifo_next.wp = fifo_reg.wp + 1'b1;
    end
    fifo_next.cnt = fifo_reg.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  // state and storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
    if (wr) begin
      mem[fifo_reg.wp] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== apm_ctrl.sv ====
// Functional notes
// - three modes: continuous measurement, low-rate wake-up sensing, standby with no sensing
// - measurement samples continuously at a selectable rate from 12.5 Hz to 400 Hz
// - wake-up mode samples only about six times per second
// - motion in wake-up may move the block to measurement on its own
// - motion in wake-up may raise the activity interrupt toward the host
// - motion may drive the awake output that wakes downstream circuits
// - in wake-up every feature works except the activity timer and the external clock and trigger, as the timer paces samples
// - in wake-up live samples stay readable and may enter the FIFO
// - standby stops all measurement until the host picks a mode again
// - entering standby keeps pending interrupts and stored samples untouched
// - standby creates no new interrupt events
// - after reset the block sits in standby with every function off
// - range of 2, 4 or 8 g on 12-bit samples; scale follows range
// - out-of-range acceleration reports full-scale code 0x0FFF, never wraps
// - secondary event pin is an interrupt output, or a sampling trigger input
// - primary event pin is an interrupt output, or an external sample clock input
`timescale 1ns/10ps
`default_nettype none
module apm_ctrl #(
  parameter logic [31:0] ODR_MAX_CYC = 32'(apm_pkg::ODR_MAX_CYC),
  parameter logic [31:0] WAKE_CYC = 32'(apm_pkg::WAKE_CYC)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apm_pkg::apm_cfg_t cfg,
  input wire logic irq_clear,
  input wire apm_pkg::apm_raw_t raw_sample,
  input wire logic primary_event_pin_i,
  output logic primary_event_pin_o,
  output logic primary_event_pin_oe,
  input wire logic secondary_event_pin_i,
  output logic secondary_event_pin_o,
  output logic secondary_event_pin_oe,
  output logic awake_out,
  output apm_pkg::apm_mode_t mode_out,
  output apm_pkg::apm_sample_t sample_out,
  output logic sample_stb,
  output logic overrun_out,
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [apm_pkg::FIFO_W-1:0] fifo_data
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    apm_pkg::apm_mode_t mode;
    apm_pkg::apm_mode_t req_seen;
    logic [31:0] cnt;
    logic [7:0] act_cnt;
    logic act_pend;
    logic drdy_pend;
    logic awake;
    logic overrun;
    logic pend;
    logic stb;
    apm_pkg::apm_sample_t smp;
    logic [2:0] p_sy;
    logic p_lv;
    logic [2:0] s_sy;
    logic s_lv;
  } apm_ctl_t;

  apm_ctl_t ctl_reg, ctl_next;
  logic pri_rise, sec_rise, timer_exp;
  logic meas_tick, smp_tick, boundary;
  logic busy, motion, act_hit;
  logic fifo_in_ready;
  logic signed [15:0] scaled [apm_pkg::AXES];
  apm_pkg::apm_sample_t clipped;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // reload value for the sample timer in a given mode
  function automatic logic [31:0] period_of(apm_pkg::apm_mode_t m, logic [2:0] odr);
    logic [2:0] sh;
    sh = (odr > apm_pkg::ODR_TOP) ? 3'h0 : 3'(apm_pkg::ODR_TOP - odr);
    if (m == apm_pkg::MODE_WAKE) begin
      period_of = WAKE_CYC;
    end else begin
      period_of = ODR_MAX_CYC << sh;
    end
  endfunction

  // raw front-end counts are 1 mg each; wider ranges drop low bits
  function automatic logic signed [15:0] scale_axis(logic signed [15:0] raw,
                                                    apm_pkg::apm_range_t rg);
    logic [1:0] sh;
    case (rg)
      apm_pkg::RANGE_2G: sh = 2'h0;
      apm_pkg::RANGE_4G: sh = 2'h1;
      default: sh = 2'h2;
    endcase
    scale_axis = raw >>> sh;
  endfunction

  // report full-scale code 0x0FFF in either direction instead of wrapping into the 12-bit field
  function automatic logic [11:0] clip_axis(logic signed [15:0] v);
    if (v > apm_pkg::SMP_MAX || v < apm_pkg::SMP_MIN) begin
      clip_axis = apm_pkg::FULL_SCALE_CODE;
    end else begin
      clip_axis = v[11:0];
    end
  endfunction

  // magnitude test works on the unclipped value, so clipping never hides motion
  function automatic logic over_thresh(logic signed [15:0] v, logic [11:0] th);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : 16'(v);
    over_thresh = mag > {4'h0, th};
  endfunction

  // ****************************************************************
  // per-axis datapath
  // ****************************************************************
  for (genvar a = 0; a < apm_pkg::AXES; a++) begin : g_axis
    assign scaled[a] = scale_axis(raw_sample[a], cfg.range);
    assign clipped[a] = clip_axis(scaled[a]);
  end

  // motion if any axis passes the threshold
  always_comb begin
    motion = 1'b0;
    for (int a = 0; a < apm_pkg::AXES; a++) begin
      motion = motion | over_thresh(scaled[a], cfg.act_thresh);
    end
  end

  // ****************************************************************
  // pin edges and sample ticks
  // ****************************************************************
  // a new level counts once stages two and three agree
  assign pri_rise = (ctl_reg.p_sy[2:1] == 2'b11) & ~ctl_reg.p_lv;
  assign sec_rise = (ctl_reg.s_sy[2:1] == 2'b11) & ~ctl_reg.s_lv;
  assign timer_exp = ctl_reg.cnt == 32'h0000_0000;

  // tick source in measurement: external clock, trigger, else timer
  // with an idle external clock no boundary comes, so mode changes wait
  always_comb begin
    if (cfg.ext_clk_en) begin
      meas_tick = pri_rise;
    end else if (cfg.sync_en) begin
      meas_tick = sec_rise;
    end else begin
      meas_tick = timer_exp;
    end
  end

  // standby takes no samples; its timer only marks boundaries
  always_comb begin
    case (ctl_reg.mode)
      apm_pkg::MODE_MEAS: begin
        smp_tick = meas_tick;
        boundary = meas_tick;
      end
      apm_pkg::MODE_WAKE: begin
        smp_tick = timer_exp;
        boundary = timer_exp;
      end
      default: begin
        smp_tick = 1'b0;
        boundary = timer_exp;
      end
    endcase
  end

  // a sample still waiting for the FIFO stalls the next capture
  assign busy = ctl_reg.pend & ~fifo_in_ready;

  // activity timer only in measurement; wake-up acts on one sample
  always_comb begin
    if (ctl_reg.mode == apm_pkg::MODE_WAKE) begin
      act_hit = smp_tick & motion;
    end else begin
      act_hit = smp_tick & motion &
                (({1'b0, ctl_reg.act_cnt} + 9'h001) >= {1'b0, cfg.act_time});
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.stb = 1'b0;

    // three-stage synchronisers for both event pins
    ctl_next.p_sy = {ctl_reg.p_sy[1:0], primary_event_pin_i};
    ctl_next.s_sy = {ctl_reg.s_sy[1:0], secondary_event_pin_i};
    if (ctl_reg.p_sy[1] == ctl_reg.p_sy[2]) begin
      ctl_next.p_lv = ctl_reg.p_sy[2];
    end
    if (ctl_reg.s_sy[1] == ctl_reg.s_sy[2]) begin
      ctl_next.s_lv = ctl_reg.s_sy[2];
    end

    // host clears first so a same-cycle event wins
    if (irq_clear) begin
      ctl_next.act_pend = 1'b0;
      ctl_next.drdy_pend = 1'b0;
      ctl_next.overrun = 1'b0;
    end

    // FIFO accepted the waiting sample
    if (ctl_reg.pend & fifo_in_ready) begin
      ctl_next.pend = 1'b0;
    end

    // capture a sample at each tick of an active mode unless busy, which flags overrun instead
    if (smp_tick) begin
      if (busy) begin
        ctl_next.overrun = 1'b1;
      end else begin
        ctl_next.smp = clipped;
        ctl_next.stb = 1'b1;
        ctl_next.pend = cfg.fifo_en;
        ctl_next.drdy_pend = 1'b1;
      end
      if (motion) begin
        if (ctl_reg.act_cnt != 8'hFF) begin
          ctl_next.act_cnt = ctl_reg.act_cnt + 8'h01;
        end
      end else begin
        ctl_next.act_cnt = 8'h00;
      end
    end

    // activity response
    if (act_hit) begin
      if (cfg.irq_en) begin
        ctl_next.act_pend = 1'b1;
      end
      ctl_next.awake = 1'b1;
      if (ctl_reg.mode == apm_pkg::MODE_WAKE && cfg.auto_meas_en) begin
        ctl_next.mode = apm_pkg::MODE_MEAS;
        ctl_next.act_cnt = 8'h00;
      end
    end

    // host mode request, applied only on a boundary; flags and data kept, except awake, which a standby request drops
    if (boundary && cfg.mode_req != ctl_reg.req_seen) begin
      ctl_next.mode = cfg.mode_req;
      ctl_next.req_seen = cfg.mode_req;
      ctl_next.act_cnt = 8'h00;
      if (cfg.mode_req == apm_pkg::MODE_STANDBY) begin
        ctl_next.awake = 1'b0;
      end
    end

    // sample timer reloads for the mode now in force
    if (timer_exp) begin
      ctl_next.cnt = period_of(ctl_next.mode, cfg.odr) - 32'h0000_0001;
    end else begin
      ctl_next.cnt = ctl_reg.cnt - 32'h0000_0001;
    end
  end

  // all-zero reset puts the block in standby, everything off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ****************************************************************
  // sample buffer
  // ****************************************************************
  apm_fifo #(
    .WIDTH(apm_pkg::FIFO_W),
    .DEPTH(apm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(ctl_reg.pend),
    .in_ready(fifo_in_ready),
    .in_data(ctl_reg.smp),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // a pin set up as input is released so the host drives it alone
  assign primary_event_pin_o = ctl_reg.act_pend;
  assign primary_event_pin_oe = ~cfg.ext_clk_en;
  assign secondary_event_pin_o = ctl_reg.drdy_pend;
  assign secondary_event_pin_oe = ~cfg.sync_en;
  assign awake_out = ctl_reg.awake & cfg.awake_en;
  assign mode_out = ctl_reg.mode;
  assign sample_out = ctl_reg.smp;
  assign sample_stb = ctl_reg.stb;
  assign overrun_out = ctl_reg.overrun;
endmodule
`default_nettype wire

// ==== apm_ctrl_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module apm_ctrl_props #(
  parameter logic [31:0] ODR_MAX_CYC = 32'h0000_0028,
  parameter logic [31:0] WAKE_CYC = 32'h0000_0064
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apm_pkg::apm_cfg_t cfg,
  input wire logic irq_clear,
  input wire logic primary_event_pin_o,
  input wire logic primary_event_pin_oe,
  input wire logic secondary_event_pin_o,
  input wire logic secondary_event_pin_oe,
  input wire logic awake_out,
  input wire apm_pkg::apm_mode_t mode_out,
  input wire apm_pkg::apm_sample_t sample_out,
  input wire logic sample_stb,
  input wire logic overrun_out
);
  logic [31:0] gap_reg;
  logic wake_reg;
  // cycles since last strobe; wake_reg only once wake is settled, so the
  // switch-over strobe never starts a wake interval
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_reg <= 32'h0000_0000;
      wake_reg <= 1'b0;
    end else if (sample_stb) begin
      gap_reg <= 32'h0000_0001;
      wake_reg <= (mode_out == apm_pkg::MODE_WAKE) && ($past(mode_out) == apm_pkg::MODE_WAKE);
    end else begin
      gap_reg <= gap_reg + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // properties
  // ****************************************************************
  a_primary_oe: assert property (primary_event_pin_oe == !cfg.ext_clk_en)
    else $error("primary pin enable wrong");
  a_secondary_oe: assert property (secondary_event_pin_oe == !cfg.sync_en)
    else $error("secondary pin enable wrong");
  a_standby_quiet: assert property (mode_out == apm_pkg::MODE_STANDBY |=> !sample_stb)
    else $error("sample taken in standby");
  a_no_new_irq: assert property (
    (mode_out == apm_pkg::MODE_STANDBY && !primary_event_pin_o)
    ##1 $stable(cfg.irq_en) |-> !primary_event_pin_o)
    else $error("interrupt raised in standby");
  a_sample_hold: assert property (!sample_stb && $past(rst_n) |-> $stable(sample_out))
    else $error("sample changed without strobe");
  a_irq_sticky: assert property (primary_event_pin_o && !irq_clear |=> primary_event_pin_o)
    else $error("pending interrupt lost");
  a_overrun_sticky: assert property (overrun_out && !irq_clear |=> overrun_out)
    else $error("overrun flag lost");
  a_drdy_follow: assert property (sample_stb |-> secondary_event_pin_o)
    else $error("data ready missing with strobe");
  // awake is dropped by the standby request itself, so it never shows in standby
  a_awake_gate: assert property (awake_out |-> cfg.awake_en && mode_out != apm_pkg::MODE_STANDBY)
    else $error("awake without enable");
  a_meas_boundary: assert property (mode_out == apm_pkg::MODE_MEAS
    ##1 mode_out != apm_pkg::MODE_MEAS |-> sample_stb)
    else $error("left measurement off a sample boundary");
  a_wake_period: assert property (sample_stb && wake_reg
    && mode_out == apm_pkg::MODE_WAKE |-> gap_reg == WAKE_CYC)
    else $error("wake poll spacing wrong");
  cover property (mode_out == apm_pkg::MODE_WAKE ##1 mode_out == apm_pkg::MODE_MEAS);
  cover property ($rose(overrun_out));
  cover property (sample_stb && gap_reg == ODR_MAX_CYC);
  cover property (sample_stb && cfg.ext_clk_en);
endmodule
bind apm_ctrl apm_ctrl_props #(.ODR_MAX_CYC(ODR_MAX_CYC), .WAKE_CYC(WAKE_CYC)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .irq_clear(irq_clear),
  .primary_event_pin_o(primary_event_pin_o), .primary_event_pin_oe(primary_event_pin_oe),
  .secondary_event_pin_o(secondary_event_pin_o),
  .secondary_event_pin_oe(secondary_event_pin_oe), .awake_out(awake_out),
  .mode_out(mode_out), .sample_out(sample_out), .sample_stb(sample_stb),
  .overrun_out(overrun_out));
`default_nettype wire

// ==== apm_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module apm_host_model (
  input wire logic primary_event_pin_o,
  input wire logic primary_event_pin_oe,
  input wire logic secondary_event_pin_o,
  input wire logic secondary_event_pin_oe,
  output logic primary_event_pin_i,
  output logic secondary_event_pin_i
);
  logic clk_drv;
  logic trig_drv;
  // wire level: the device drives while enabled, else the host's level
  assign primary_event_pin_i = primary_event_pin_oe ? primary_event_pin_o : clk_drv;
  assign secondary_event_pin_i = secondary_event_pin_oe ? secondary_event_pin_o : trig_drv;
  initial begin
    clk_drv = 1'b0;
    trig_drv = 1'b0;
  end
  // external sample clock, 125 ns period, parked low between frames
  task automatic send_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #62.5 clk_drv = 1'b1;
      #62.5 clk_drv = 1'b0;
    end
  endtask
  // sync triggers, wide enough for the pin synchroniser
  task automatic send_triggers(input int n);
    for (int i = 0; i < n; i++) begin
      trig_drv = 1'b1;
      #50 trig_drv = 1'b0;
      #150;
    end
  endtask
endmodule
`default_nettype wire

// ==== apm_ctrl_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module apm_ctrl_bench;
  localparam logic [31:0] ODR_CYC = 32'h0000_0028;
  localparam logic [31:0] WAKE_CYC = 32'h0000_0064;
  typedef struct packed {
    logic [1:0] rng;
    apm_pkg::apm_raw_t raw;
    apm_pkg::apm_sample_t exp;
  } apm_row_t;
  // axis2, axis1, axis0: in range, edges, and both clip directions
  apm_row_t rows [5] = '{
    '{2'h0, {16'h07FF, 16'hFF9C, 16'h0064}, {12'h7FF, 12'hF9C, 12'h064}},
    '{2'h0, {16'h0800, 16'hF7FF, 16'hF800}, {12'hFFF, 12'hFFF, 12'h800}},
    '{2'h1, {16'h0FFF, 16'h1000, 16'hFF38}, {12'h7FF, 12'hFFF, 12'hF9C}},
    '{2'h2, {16'h1FFF, 16'h2000, 16'hFFF8}, {12'h7FF, 12'hFFF, 12'hFFE}},
    '{2'h3, {16'h1FFC, 16'hE000, 16'h0010}, {12'h7FF, 12'h800, 12'h004}}};
  logic core_clk, rst_n, irq_clear, fifo_ready, fifo_valid, sample_stb, overrun_out, awake_out;
  logic p_i, p_o, p_oe, s_i, s_o, s_oe;
  apm_pkg::apm_cfg_t cfg;
  apm_pkg::apm_raw_t raw;
  apm_pkg::apm_mode_t mode_out;
  apm_pkg::apm_sample_t sample_out;
  logic [apm_pkg::FIFO_W-1:0] fifo_data;
  int failures, tests_run, stb_cnt, gap_cyc, n0, words;
  apm_ctrl #(.ODR_MAX_CYC(ODR_CYC), .WAKE_CYC(WAKE_CYC)) uut (.core_clk(core_clk),
    .rst_n(rst_n), .cfg(cfg), .irq_clear(irq_clear), .raw_sample(raw),
    .primary_event_pin_i(p_i), .primary_event_pin_o(p_o), .primary_event_pin_oe(p_oe),
    .secondary_event_pin_i(s_i), .secondary_event_pin_o(s_o), .secondary_event_pin_oe(s_oe),
    .awake_out(awake_out), .mode_out(mode_out), .sample_out(sample_out),
    .sample_stb(sample_stb), .overrun_out(overrun_out), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .fifo_data(fifo_data));
  apm_host_model host (.primary_event_pin_o(p_o), .primary_event_pin_oe(p_oe),
    .secondary_event_pin_o(s_o), .secondary_event_pin_oe(s_oe),
    .primary_event_pin_i(p_i), .secondary_event_pin_i(s_i));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // strobes counted off the edge so counts never race the design
  always @(negedge core_clk) begin
    if (sample_stb === 1'b1) stb_cnt++;
  end
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_stb();
    int i;
    i = 0;
    do begin @(negedge core_clk); i++; end while (sample_stb !== 1'b1 && i < 4000);
    check("strobe", 1'b1, sample_stb);
  endtask
  task automatic wait_mode(input apm_pkg::apm_mode_t m);
    int i;
    i = 0;
    while (mode_out !== m && i < 4000) begin @(negedge core_clk); i++; end
    check("mode", m, mode_out);
  endtask
  // cycles between two strobes
  task automatic measure();
    wait_stb();
    gap_cyc = 0;
    do begin @(negedge core_clk); gap_cyc++; end while (sample_stb !== 1'b1 && gap_cyc < 4000);
  endtask
  task automatic pulse_clear();
    irq_clear = 1'b1;
    @(negedge core_clk);
    irq_clear = 1'b0;
  endtask
  task automatic complete_run();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog, several times the expected run length
  initial begin
    #400us;
    failures++;
    complete_run();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    cfg = '0; // config lands whole, as one framed host transfer
    irq_clear = 1'b0;
    raw = '0;
    fifo_ready = 1'b1;
    cycles(20);
    rst_n = 1'b1;
    @(negedge core_clk);
    check("reset", 36'h0, {mode_out, p_o, s_o, awake_out, sample_stb, overrun_out, fifo_valid});
    cycles(300);
    check("standby_ticks", 36'h0, stb_cnt);
    cfg.mode_req = apm_pkg::MODE_MEAS;
    wait_mode(apm_pkg::MODE_MEAS);
    for (int k = 0; k < 6; k++) begin
      cfg.odr = 3'(k);
      wait_stb();
      measure();
      check("odr_gap", ODR_CYC << (5 - k), 36'(gap_cyc));
    end
    foreach (rows[i]) begin
      cfg.range = apm_pkg::apm_range_t'(rows[i].rng);
      raw = rows[i].raw;
      wait_stb();
      wait_stb();
      check("sample", rows[i].exp, sample_out);
    end
    // wake-up: slow poll, then one moving sample acts at once
    raw = '0;
    cfg.mode_req = apm_pkg::MODE_STANDBY;
    wait_mode(apm_pkg::MODE_STANDBY);
    pulse_clear();
    cfg.act_thresh = 12'h1F4;
    cfg.act_time = 8'h03;
    // threshold is in scaled counts, so go back to the finest range
    cfg.range = apm_pkg::RANGE_2G;
    {cfg.auto_meas_en, cfg.irq_en, cfg.awake_en} = 3'h7;
    cfg.mode_req = apm_pkg::MODE_WAKE;
    wait_mode(apm_pkg::MODE_WAKE);
    measure();
    check("wake_gap", WAKE_CYC, 36'(gap_cyc));
    check("quiet_irq", 1'b0, p_o);
    raw = {16'h0000, 16'h0000, 16'h0258};
    n0 = 0;
    while (p_o !== 1'b1 && n0 < 300) begin @(negedge core_clk); n0++; end
    check("wake_irq", 1'b1, p_o);
    check("awake", 1'b1, awake_out);
    check("auto_mode", apm_pkg::MODE_MEAS, mode_out);
    // standby keeps pending state and makes nothing new
    raw = '0;
    wait_stb();
    wait_stb();
    cfg.mode_req = apm_pkg::MODE_STANDBY;
    wait_mode(apm_pkg::MODE_STANDBY);
    cycles(2);
    n0 = stb_cnt;
    cycles(200);
    check("kept_irq", 1'b1, p_o);
    check("kept_sample", 36'h0, sample_out);
    check("awake_off", 1'b0, awake_out);
    pulse_clear();
    raw = {16'h0000, 16'h0000, 16'h0258};
    cycles(200);
    check("no_new_irq", 1'b0, p_o);
    check("standby_ticks", n0, stb_cnt);
    // external clock on the primary pin
    raw = '0;
    cfg.ext_clk_en = 1'b1;
    cfg.mode_req = apm_pkg::MODE_MEAS;
    wait_mode(apm_pkg::MODE_MEAS);
    check("primary_oe", 1'b0, p_oe);
    cycles(5);
    n0 = stb_cnt;
    host.send_clocks(8);
    cycles(10);
    check("ext_ticks", 36'h8, stb_cnt - n0);
    // sync trigger on the secondary pin
    cfg.ext_clk_en = 1'b0;
    cfg.sync_en = 1'b1;
    cycles(5);
    check("secondary_oe", 1'b0, s_oe);
    n0 = stb_cnt;
    host.send_triggers(3);
    cycles(10);
    check("sync_ticks", 36'h3, stb_cnt - n0);
    // fifo: fill past full, then drain with a stalling reader
    cfg.sync_en = 1'b0;
    raw = {16'h0000, 16'h0000, 16'h0100};
    cfg.fifo_en = 1'b1;
    fifo_ready = 1'b0;
    pulse_clear();
    cycles(ODR_CYC * 20);
    check("overrun", 1'b1, overrun_out);
    // a stalled tick would leave without a sample, so free one slot and
    // leave measurement on a single external tick instead
    cfg.ext_clk_en = 1'b1;
    fifo_ready = 1'b1;
    @(negedge core_clk);
    fifo_ready = 1'b0;
    cycles(5);
    cfg.mode_req = apm_pkg::MODE_STANDBY;
    host.send_clocks(1);
    wait_mode(apm_pkg::MODE_STANDBY);
    cfg.ext_clk_en = 1'b0;
    words = 0;
    for (int i = 0; i < 200; i++) begin
      fifo_ready = i[0];
      if (fifo_valid === 1'b1 && fifo_ready) begin
        words++;
        check("fifo_data", 36'h0_0000_0100, fifo_data);
      end
      @(negedge core_clk);
    end
    check("words", 1'b1, words >= 17);
    check("drained", 1'b0, fifo_valid);
    // second reset in mid-run
    rst_n = 1'b0;
    cycles(2);
    rst_n = 1'b1;
    @(negedge core_clk);
    check("rereset", 36'h0, {mode_out, overrun_out, p_o});
    complete_run();
  end
endmodule
`default_nettype wire
